// ### logic/optcfg_pkg.sv
`default_nettype none
package optcfg_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;

  // Feature enable bits of the control register.
  localparam int CTRL_W = 5;
  localparam int CTRL_USER_CLK = 0;
  localparam int CTRL_INIT_DONE = 1;
  localparam int CTRL_CAL_GATE = 2;
  localparam int CTRL_DEVICE_WIDE_OUTPUT_ENABLE = 3;
  localparam int CTRL_DEV_CLR = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // Status register fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DRIVE_LOW = 4;
  localparam int STAT_USER_MODE = 5;
  localparam int STAT_CAL_DONE = 6;
  localparam int STAT_OE_FORCED = 7;
  localparam int STAT_CLR_FORCED = 8;

  // Interrupt event bits, shared by status and mask.
  localparam int IRQ_W = 4;
  localparam int IRQ_USER_MODE = 0;
  localparam int IRQ_RESTART = 1;
  localparam int IRQ_CAL_DONE = 2;
  localparam int IRQ_FRAME = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  // Optional pin positions.
  localparam int NUM_OPT_PINS = 4;
  localparam int PIN_USER_CLK = 0;
  localparam int PIN_INIT_DONE = 1;
  localparam int PIN_DEVICE_WIDE_OUTPUT_ENABLE = 2;
  localparam int PIN_DEV_CLR = 3;

  // Start-up timing.
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int INT_CLK_PERIOD_NS = 1000;
  localparam int INT_DIV_RAW = INT_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int INT_DIV_CYCLES = (INT_DIV_RAW < 1) ? 1 : INT_DIV_RAW;
  localparam int INIT_TICKS = 16;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_CONFIG,
    ST_INIT,
    ST_CAL_WAIT,
    ST_USER
  } cfg_state_e;

endpackage
`default_nettype wire

// ### logic/opt_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module opt_pin_cell (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Selection.
  input wire logic i_feature_en,
  input wire logic i_user_mode,
  input wire logic i_global_oe_ok,
  // Feature side.
  input wire logic i_feature_out,
  input wire logic i_feature_oe,
  // Core side, used when the pin is plain user I/O.
  input wire logic i_core_out,
  input wire logic i_core_oe,
  // Pad.
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_pad_pullup
);

  logic next_pad_out;
  logic next_pad_oe;
  logic next_pad_pullup;

  always_comb begin
    next_pad_out = 1'b0;
    next_pad_oe = 1'b0;
    next_pad_pullup = 1'b0;
    if (i_feature_en) begin
      next_pad_out = i_feature_out;
      next_pad_oe = i_feature_oe;
    end else if (!i_user_mode) begin
      next_pad_pullup = 1'b1;
    end else begin
      next_pad_out = i_core_out;
      next_pad_oe = i_core_oe & i_global_oe_ok;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_out <= 1'b0;
      o_pad_oe <= 1'b0;
      o_pad_pullup <= 1'b1;
    end else begin
      o_pad_out <= next_pad_out;
      o_pad_oe <= next_pad_oe;
      o_pad_pullup <= next_pad_pullup;
    end
  end

endmodule // opt_pin_cell
`default_nettype wire

// ### logic/optional_config_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
module optional_config_pin_control (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [optcfg_pkg::ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [optcfg_pkg::DATA_W-1:0] i_wb_dat,
  output logic [optcfg_pkg::DATA_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  // Configuration sequence.
  input wire logic i_config_request_n,
  input wire logic i_first_frame_loaded,
  input wire logic i_config_data_done,
  input wire logic i_termination_cal_complete,
  // Optional pins as seen from the pads.
  input wire logic [optcfg_pkg::NUM_OPT_PINS-1:0] i_pad_in,
  output logic [optcfg_pkg::NUM_OPT_PINS-1:0] o_pad_out,
  output logic [optcfg_pkg::NUM_OPT_PINS-1:0] o_pad_oe,
  output logic [optcfg_pkg::NUM_OPT_PINS-1:0] o_pad_pullup,
  // Core use of optional pins when their feature is off.
  input wire logic [optcfg_pkg::NUM_OPT_PINS-1:0] i_core_out,
  input wire logic [optcfg_pkg::NUM_OPT_PINS-1:0] i_core_oe,
  output logic [optcfg_pkg::NUM_OPT_PINS-1:0] o_core_in,
  // Device-wide controls and status.
  output logic o_io_oe_allow,
  output logic o_reg_clear_n,
  output logic o_user_mode,
  output logic o_irq
);

  import optcfg_pkg::*;

  // Register file state.
  logic [CTRL_W-1:0] ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [CTRL_W-1:0] next_ctrl;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [DATA_W-1:0] next_wb_dat;
  logic next_wb_ack;
  logic next_irq;

  // Sequencer state.
  cfg_state_e state;
  cfg_state_e next_state;
  logic drive_low;
  logic next_drive_low;
  logic [CNT_W-1:0] div_cnt;
  logic [CNT_W-1:0] next_div_cnt;
  logic [CNT_W-1:0] tick_cnt;
  logic [CNT_W-1:0] next_tick_cnt;
  logic user_clk_prev;
  logic next_user_clk_prev;
  logic cal_prev;
  logic next_cal_prev;
  logic init_tick;
  logic [IRQ_W-1:0] events;

  // Override state.
  logic next_io_oe_allow;
  logic next_reg_clear_n;
  logic next_user_mode;
  logic [NUM_OPT_PINS-1:0] next_core_in;

  logic bus_req;
  logic bus_wr;
  logic [DATA_W-1:0] status_word;

  assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign bus_wr = bus_req & i_wb_we & i_wb_sel[0];

  // Initialization clock: either rising edges of the user clock pin or the internal divider.
  always_comb begin
    next_user_clk_prev = i_pad_in[PIN_USER_CLK];
    next_div_cnt = div_cnt + 8'h01;
    if (div_cnt == CNT_W'(INT_DIV_CYCLES - 1)) begin
      next_div_cnt = 8'h00;
    end
    if (ctrl[CTRL_USER_CLK]) begin
      init_tick = i_pad_in[PIN_USER_CLK] & ~user_clk_prev;
    end else begin
      init_tick = (div_cnt == CNT_W'(INT_DIV_CYCLES - 1));
    end
  end

  // Configuration sequencer.
  always_comb begin
    next_state = state;
    next_drive_low = drive_low;
    next_tick_cnt = tick_cnt;
    next_cal_prev = i_termination_cal_complete;
    events = IRQ_RESET;
    if (!i_config_request_n) begin
      if (state != ST_HOLD) begin
        events[IRQ_RESTART] = 1'b1;
      end
      next_state = ST_HOLD;
      next_drive_low = 1'b0;
      next_tick_cnt = 8'h00;
    end else begin
      case (state)
        ST_HOLD: begin
          next_state = ST_CONFIG;
          next_drive_low = 1'b0;
        end
        ST_CONFIG: begin
          if (i_first_frame_loaded && ctrl[CTRL_INIT_DONE]) begin
            next_drive_low = 1'b1;
          end
          if (i_first_frame_loaded) begin
            events[IRQ_FRAME] = 1'b1;
          end
          if (i_config_data_done) begin
            next_state = ST_INIT;
            next_tick_cnt = 8'h00;
          end
        end
        ST_INIT: begin
          if (init_tick) begin
            next_tick_cnt = tick_cnt + 8'h01;
            if (tick_cnt == CNT_W'(INIT_TICKS - 1)) begin
              next_state = ST_CAL_WAIT;
            end
          end
        end
        ST_CAL_WAIT: begin
          // Gating waits for calibration only when its option is on.
          if (!ctrl[CTRL_CAL_GATE] || i_termination_cal_complete) begin
            next_state = ST_USER;
            next_drive_low = 1'b0;
            events[IRQ_USER_MODE] = 1'b1;
          end
        end
        ST_USER: begin
          next_drive_low = 1'b0;
        end
        default: begin
          next_state = ST_HOLD;
        end
      endcase
    end
    if (i_termination_cal_complete && !cal_prev) begin
      events[IRQ_CAL_DONE] = 1'b1;
    end
  end

  // Device-wide overrides follow their pin level on every clock, in any state.
  always_comb begin
    next_io_oe_allow = 1'b1;
    next_reg_clear_n = 1'b1;
    if (ctrl[CTRL_DEVICE_WIDE_OUTPUT_ENABLE] && !i_pad_in[PIN_DEVICE_WIDE_OUTPUT_ENABLE]) begin
      next_io_oe_allow = 1'b0;
    end
    if (ctrl[CTRL_DEV_CLR] && !i_pad_in[PIN_DEV_CLR]) begin
      next_reg_clear_n = 1'b0;
    end
    // User mode follows the registered state, so it rises on the same edge at which
    // the status pin's pad register lets the line go.
    next_user_mode = (state == ST_USER);
    next_core_in = i_pad_in;
    if (ctrl[CTRL_USER_CLK]) begin
      next_core_in[PIN_USER_CLK] = 1'b0;
    end
    if (ctrl[CTRL_DEVICE_WIDE_OUTPUT_ENABLE]) begin
      next_core_in[PIN_DEVICE_WIDE_OUTPUT_ENABLE] = 1'b0;
    end
    if (ctrl[CTRL_DEV_CLR]) begin
      next_core_in[PIN_DEV_CLR] = 1'b0;
    end
    if (ctrl[CTRL_INIT_DONE]) begin
      next_core_in[PIN_INIT_DONE] = 1'b0;
    end
  end

  // Register file and Wishbone answer.
  always_comb begin
    status_word = '0;
    status_word[STAT_STATE_LSB +: 3] = state;
    status_word[STAT_DRIVE_LOW] = drive_low;
    status_word[STAT_USER_MODE] = o_user_mode;
    status_word[STAT_CAL_DONE] = i_termination_cal_complete;
    status_word[STAT_OE_FORCED] = ~o_io_oe_allow;
    status_word[STAT_CLR_FORCED] = ~o_reg_clear_n;
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    // A new event wins over a write-one-to-clear in the same cycle.
    next_irq_status = irq_status;
    if (bus_wr && i_wb_adr == REG_IRQ_STATUS) begin
      next_irq_status = irq_status & ~i_wb_dat[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | events;
    if (bus_wr && i_wb_adr == REG_CTRL) begin
      next_ctrl = i_wb_dat[CTRL_W-1:0];
    end else if (bus_wr && i_wb_adr == REG_IRQ_MASK) begin
      next_irq_mask = i_wb_dat[IRQ_W-1:0];
    end
    next_wb_dat = '0;
    if (bus_req && !i_wb_we) begin
      if (i_wb_adr == REG_CTRL) begin
        next_wb_dat[CTRL_W-1:0] = ctrl;
      end else if (i_wb_adr == REG_STATUS) begin
        next_wb_dat = status_word;
      end else if (i_wb_adr == REG_IRQ_STATUS) begin
        next_wb_dat[IRQ_W-1:0] = irq_status;
      end else if (i_wb_adr == REG_IRQ_MASK) begin
        next_wb_dat[IRQ_W-1:0] = irq_mask;
      end else begin
        next_wb_dat = '0;
      end
    end
    next_wb_ack = bus_req;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RESET;
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      o_wb_dat <= '0;
      o_wb_ack <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      o_wb_dat <= next_wb_dat;
      o_wb_ack <= next_wb_ack;
      o_irq <= next_irq;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_HOLD;
      drive_low <= 1'b0;
      div_cnt <= 8'h00;
      tick_cnt <= 8'h00;
      user_clk_prev <= 1'b0;
      cal_prev <= 1'b0;
      o_io_oe_allow <= 1'b1;
      o_reg_clear_n <= 1'b1;
      o_user_mode <= 1'b0;
      o_core_in <= '0;
    end else begin
      state <= next_state;
      drive_low <= next_drive_low;
      div_cnt <= next_div_cnt;
      tick_cnt <= next_tick_cnt;
      user_clk_prev <= next_user_clk_prev;
      cal_prev <= next_cal_prev;
      o_io_oe_allow <= next_io_oe_allow;
      o_reg_clear_n <= next_reg_clear_n;
      o_user_mode <= next_user_mode;
      o_core_in <= next_core_in;
    end
  end

  // Per-pin feature values: only the status pin ever drives, and only low (open drain).
  logic [NUM_OPT_PINS-1:0] feature_oe;
  logic [NUM_OPT_PINS-1:0] feature_en;
  assign feature_oe = {2'b00, drive_low, 1'b0};
  assign feature_en = {ctrl[CTRL_DEV_CLR], ctrl[CTRL_DEVICE_WIDE_OUTPUT_ENABLE],
                       ctrl[CTRL_INIT_DONE], ctrl[CTRL_USER_CLK]};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OPT_PINS; gi++) begin : g_pin
      opt_pin_cell u_cell (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_feature_en(feature_en[gi]),
        .i_user_mode(next_user_mode),
        .i_global_oe_ok(next_io_oe_allow),
        .i_feature_out(1'b0),
        .i_feature_oe(feature_oe[gi]),
        .i_core_out(i_core_out[gi]),
        .i_core_oe(i_core_oe[gi]),
        .o_pad_out(o_pad_out[gi]),
        .o_pad_oe(o_pad_oe[gi]),
        .o_pad_pullup(o_pad_pullup[gi])
      );
    end
  endgenerate

endmodule // optional_config_pin_control
`default_nettype wire

// ### bench/optcfg_sva.sv
`timescale 1ns/1ps
`default_nettype none
module optcfg_sva (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Inputs.
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_config_request_n,
  input wire logic i_first_frame_loaded,
  input wire logic i_termination_cal_complete,
  input wire logic [3:0] i_pad_in,
  // Outputs.
  input wire logic o_wb_ack,
  input wire logic [3:0] o_pad_out,
  input wire logic [3:0] o_pad_oe,
  input wire logic [3:0] o_pad_pullup,
  input wire logic o_io_oe_allow,
  input wire logic o_reg_clear_n,
  input wire logic o_user_mode
);
  import optcfg_pkg::*;
  logic [CTRL_W-1:0] ctl;
  // Shadow of the option word; it trails the real one by a cycle, so the
  // checks only lean on it while options stay put.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl <= CTRL_RESET;
    end else if (o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == REG_CTRL) begin
      ctl <= i_wb_dat[CTRL_W-1:0];
    end
  end
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_cal_low;
    (ctl[CTRL_CAL_GATE] && !i_termination_cal_complete) [*3];
  endsequence
  sequence s_oe_high;
    (i_pad_in[PIN_DEVICE_WIDE_OUTPUT_ENABLE] || !ctl[CTRL_DEVICE_WIDE_OUTPUT_ENABLE]) [*3];
  endsequence
  chk_req_hold: assert property (
    !i_config_request_n |=> ##1 !o_pad_oe[PIN_INIT_DONE]) else $error("init pin driven in hold");
  chk_frame_drive: assert property (
    $rose(o_pad_oe[PIN_INIT_DONE]) |-> $past(i_first_frame_loaded, 2)) else $error("early drive");
  chk_user_rel: assert property (
    ctl[CTRL_INIT_DONE] && $rose(o_user_mode) |-> $fell(o_pad_oe[PIN_INIT_DONE]))
    else $error("init pin not released");
  chk_pull_tri: assert property (
    (o_pad_oe & o_pad_pullup) == 4'h0) else $error("pull-up on a driven pin");
  chk_cal_hold: assert property (
    s_cal_low |-> !$rose(o_user_mode)) else $error("user mode before calibration");
  chk_oe_force: assert property (
    ctl[CTRL_DEVICE_WIDE_OUTPUT_ENABLE] && !i_pad_in[PIN_DEVICE_WIDE_OUTPUT_ENABLE] |-> ##[1:2] !o_io_oe_allow)
    else $error("outputs not forced off");
  chk_oe_free: assert property (
    s_oe_high |-> o_io_oe_allow) else $error("outputs forced off");
  chk_clr_force: assert property (
    ctl[CTRL_DEV_CLR] && !i_pad_in[PIN_DEV_CLR] |-> ##[1:2] !o_reg_clear_n)
    else $error("clear not forced");
endmodule // optcfg_sva
bind optional_config_pin_control optcfg_sva chk_u (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel),
  .i_wb_dat(i_wb_dat),
  .i_config_request_n(i_config_request_n),
  .i_first_frame_loaded(i_first_frame_loaded),
  .i_termination_cal_complete(i_termination_cal_complete),
  .i_pad_in(i_pad_in),
  .o_wb_ack(o_wb_ack),
  .o_pad_out(o_pad_out),
  .o_pad_oe(o_pad_oe),
  .o_pad_pullup(o_pad_pullup),
  .o_io_oe_allow(o_io_oe_allow),
  .o_reg_clear_n(o_reg_clear_n),
  .o_user_mode(o_user_mode)
);
`default_nettype wire

// ### bench/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
  // Clock and board controls.
  input wire logic i_sys_clk,
  input wire logic i_clk_run,
  input wire logic i_oe_lvl,
  input wire logic i_clr_lvl,
  // Pads.
  input wire logic [3:0] i_pad_out,
  input wire logic [3:0] i_pad_oe,
  output logic [3:0] o_pad_in,
  output logic [7:0] o_rises
);
  logic ucl = 1'b0;
  logic last = 1'b1;
  logic [7:0] rises = 8'h00;
  // The start-up clock stands still unless a start-up is being timed.
  always @(posedge i_sys_clk) begin
    if (i_clk_run) begin
      ucl <= !ucl;
    end
  end
  // The init pin rests on the board pull-up whenever it is let go.
  assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & {i_clr_lvl, i_oe_lvl, 1'b1, ucl});
  assign o_rises = rises;
  always @(posedge i_sys_clk) begin
    last <= o_pad_in[1];
    if (o_pad_in[1] && !last) begin
      rises <= rises + 8'h01;
    end
  end
endmodule // board_model
`default_nettype wire

// ### bench/tb_optional_config_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_optional_config_pin_control;
  import optcfg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic req_n = 1'b0;
  logic frame = 1'b0;
  logic ddone = 1'b0;
  logic cal = 1'b0;
  logic run = 1'b0;
  logic oe_lvl = 1'b1;
  logic clr_lvl = 1'b1;
  logic [31:0] rdat;
  logic ack, oe_ok, clr_n, umode, irq;
  logic [3:0] pin, pout, poe, pup, cin;
  logic [7:0] rises, r0;
  int fail_count = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  optional_config_pin_control dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(req),
    .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_config_request_n(req_n),
    .i_first_frame_loaded(frame), .i_config_data_done(ddone),
    .i_termination_cal_complete(cal), .i_pad_in(pin), .o_pad_out(pout), .o_pad_oe(poe),
    .o_pad_pullup(pup), .i_core_out(4'hF), .i_core_oe(4'h1), .o_core_in(cin),
    .o_io_oe_allow(oe_ok), .o_reg_clear_n(clr_n), .o_user_mode(umode), .o_irq(irq));
  board_model board_u (.i_sys_clk(clk), .i_clk_run(run), .i_oe_lvl(oe_lvl),
    .i_clr_lvl(clr_lvl), .i_pad_out(pout), .i_pad_oe(poe), .o_pad_in(pin), .o_rises(rises));
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Ack is read before the edge's own updates land, so it is the sampled value.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    req <= 1'b0;
    if (ack !== 1'b1) begin
      fail_count++;
      close_out();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic wait_user(input int lim, input logic exp);
    int n;
    n = 0;
    while (umode !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("user mode", umode, exp);
    if (exp && umode !== 1'b1) begin
      close_out();
    end
  endtask
  task automatic boot(input logic [31:0] c);
    r0 = rises;
    wr(REG_CTRL, c);
    req_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("hold drive", poe[PIN_INIT_DONE], 1'b0);
    req_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("config pins", {poe[PIN_INIT_DONE], poe[PIN_DEV_CLR], pup[PIN_DEV_CLR]}, 3'h1);
    frame <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
    repeat (2) @(posedge clk);
    chk("frame drive", {poe[PIN_INIT_DONE], pout[PIN_INIT_DONE]}, 2'h2);
    ddone <= 1'b1;
    @(posedge clk);
    ddone <= 1'b0;
  endtask
  task automatic after_user();
    logic [31:0] q;
    @(posedge clk);
    chk("released", poe[PIN_INIT_DONE], 1'b0);
    chk("rises", rises, r0 + 8'h01);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("status", {q[STAT_USER_MODE], q[2:0]}, 4'hC);
  endtask
  task automatic s_regs();
    logic [31:0] q;
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl reset", q, 32'h0);
    wr(REG_CTRL, 32'hFFFFFFFF);
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl rw", q, 32'h1F);
    wb(1'b0, 8'h10, 32'h0, q);
    chk("unmapped", q, 32'h0);
  endtask
  // Internal timing, ungated, with calibration still low: 16 ticks of 10 cycles.
  task automatic s_internal();
    boot(32'h2);
    wait_user(120, 1'b0);
    wait_user(100, 1'b1);
    after_user();
  endtask
  task automatic s_irq();
    logic [31:0] q;
    wr(REG_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk("irq masked", irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h1);
    @(posedge clk);
    chk("irq raised", irq, 1'b1);
    wb(1'b0, REG_IRQ_STATUS, 32'h0, q);
    chk("irq events", q, 32'h9);
    wr(REG_IRQ_STATUS, 32'h1);
    @(posedge clk);
    chk("irq cleared", irq, 1'b0);
  endtask
  task automatic s_user();
    boot(32'h3);
    wait_user(300, 1'b0);
    run <= 1'b1;
    wait_user(60, 1'b1);
    run <= 1'b0;
    after_user();
  endtask
  task automatic s_cal();
    boot(32'h6);
    wait_user(300, 1'b0);
    cal <= 1'b1;
    wait_user(20, 1'b1);
    after_user();
  endtask
  task automatic s_over();
    wr(REG_CTRL, 32'h1A);
    oe_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    chk("oe forced", {oe_ok, poe[PIN_USER_CLK]}, 2'h0);
    oe_lvl <= 1'b1;
    clr_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    chk("oe free", {oe_ok, poe[PIN_USER_CLK], clr_n}, 3'h6);
    clr_lvl <= 1'b1;
    repeat (3) @(posedge clk);
    chk("clear free", clr_n, 1'b1);
    wr(REG_CTRL, 32'h2);
    oe_lvl <= 1'b0;
    clr_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    chk("options off", {oe_ok, clr_n}, 2'h3);
    chk("core in", cin, 4'h1);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_regs();
    s_internal();
    s_irq();
    s_user();
    s_cal();
    s_over();
    close_out();
  end
endmodule // tb_optional_config_pin_control
`default_nettype wire
